// File: hdl/swr_pkg.sv
//------------------------------------------------------------------------------
// What this block does
// - Nonvolatile write is self-timed from stop, done within 5 ms.
// - Period select: 00 gives 1.75 s, 01 gives 750 ms, 10 gives 250 ms.
// - After watchdog expiry reset output stays low for 250 ms.
// - On power-up reset output stays low 200 ms after supply valid.
// - Serial clock and data ignore pulses narrower than 50 ns.
// - Watchdog period elapsing unrestarted asserts reset toward the host.
// - Reset is active-low open drain, also asserted on low supply.
//------------------------------------------------------------------------------
package swr_pkg;

	localparam int unsigned CLK_HZ       = 10000000;
	localparam int unsigned NS_PER_CLK   = 100;

	// Times in their own units
	localparam int unsigned WDOG_LONG_MS   = 1750;
	localparam int unsigned WDOG_MID_MS    = 750;
	localparam int unsigned WDOG_SHORT_MS  = 250;
	localparam int unsigned WDOG_RST_MS    = 250;
	localparam int unsigned PWRUP_RST_MS   = 200;
	localparam int unsigned WRITE_CYC_MS   = 5;
	localparam int unsigned READ_WAIT_MS   = 1;
	localparam int unsigned WRITE_WAIT_MS  = 5;
	localparam int unsigned GLITCH_NS      = 50;

	// Cycle counts; long ones are parameters of the top module
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
	localparam int unsigned GLITCH_CYC     =
		(GLITCH_NS + NS_PER_CLK - 1) / NS_PER_CLK;

	localparam logic [1:0] SEL_LONG  = 2'h0;
	localparam logic [1:0] SEL_MID   = 2'h1;
	localparam logic [1:0] SEL_SHORT = 2'h2;
	localparam logic [1:0] SEL_OFF   = 2'h3;

	localparam int CW = 25;

	typedef enum logic [1:0] {
		SWR_POR  = 2'h0,
		SWR_RUN  = 2'h1,
		SWR_WRST = 2'h3
	} swr_state_e;

	typedef struct packed {
		logic scl;
		logic sda;
	} swr_bus_s;

	typedef struct packed {
		logic rd_ok;
		logic wr_ok;
		logic nv_busy;
	} swr_ready_s;

endpackage : swr_pkg

// File: hdl/swr_supervisor.sv
`timescale 1ns/1ps
module swr_supervisor #(
	parameter int unsigned WDOG_LONG_CYC  =
		swr_pkg::WDOG_LONG_MS * swr_pkg::CYC_PER_MS,
	parameter int unsigned WDOG_MID_CYC   =
		swr_pkg::WDOG_MID_MS * swr_pkg::CYC_PER_MS,
	parameter int unsigned WDOG_SHORT_CYC =
		swr_pkg::WDOG_SHORT_MS * swr_pkg::CYC_PER_MS,
	parameter int unsigned WDOG_RST_CYC   =
		swr_pkg::WDOG_RST_MS * swr_pkg::CYC_PER_MS,
	parameter int unsigned PWRUP_RST_CYC  =
		swr_pkg::PWRUP_RST_MS * swr_pkg::CYC_PER_MS,
	parameter int unsigned WRITE_CYC_CYC  =
		swr_pkg::WRITE_CYC_MS * swr_pkg::CYC_PER_MS,
	parameter int unsigned READ_WAIT_CYC  =
		swr_pkg::READ_WAIT_MS * swr_pkg::CYC_PER_MS,
	parameter int unsigned WRITE_WAIT_CYC =
		swr_pkg::WRITE_WAIT_MS * swr_pkg::CYC_PER_MS
) (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire swr_pkg::swr_bus_s   bus_raw,
	input  wire logic                supply_low,
	input  wire logic                wdog_period_sel_hi,
	input  wire logic                wdog_period_sel_lo,
	input  wire logic                access_done,
	input  wire logic                nv_write_stop,
	output      logic                reset_out_n,
	output      logic                reset_oe,
	output      swr_pkg::swr_bus_s   bus_clean,
	output      swr_pkg::swr_ready_s ready,
	output      logic                addr_nack
);

	//--------------------------------------------------------------------------
	// Input glitch filter
	//--------------------------------------------------------------------------
	swr_pkg::swr_bus_s last;
	swr_pkg::swr_bus_s next_last;
	swr_pkg::swr_bus_s next_bus_clean;
	logic [1:0]        stab_cnt;
	logic [1:0]        next_stab_cnt;

	always_comb begin
		next_last      = bus_raw;
		next_bus_clean = bus_clean;
		next_stab_cnt  = stab_cnt;
		if (bus_raw != last)
			next_stab_cnt = 2'h0;
		else if (stab_cnt < 2'(swr_pkg::GLITCH_CYC))
			next_stab_cnt = stab_cnt + 2'h1;
		else
			next_bus_clean = last;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			last      <= '1;
			bus_clean <= '1;
			stab_cnt  <= 2'h0;
		end else begin
			last      <= next_last;
			bus_clean <= next_bus_clean;
			stab_cnt  <= next_stab_cnt;
		end
	end

	//--------------------------------------------------------------------------
	// Reset sequencer and watchdog
	//--------------------------------------------------------------------------
	function automatic logic [swr_pkg::CW-1:0] wdog_limit(
		input logic [1:0] sel
	);
		case (sel)
			swr_pkg::SEL_LONG:  wdog_limit = swr_pkg::CW'(WDOG_LONG_CYC);
			swr_pkg::SEL_MID:   wdog_limit = swr_pkg::CW'(WDOG_MID_CYC);
			swr_pkg::SEL_SHORT: wdog_limit = swr_pkg::CW'(WDOG_SHORT_CYC);
			default:            wdog_limit = '0;
		endcase
	endfunction : wdog_limit

	swr_pkg::swr_state_e    state;
	swr_pkg::swr_state_e    next_state;
	logic [swr_pkg::CW-1:0] cnt;
	logic [swr_pkg::CW-1:0] next_cnt;
	logic [1:0]             sel;
	logic                   next_reset_out_n;

	assign sel = {wdog_period_sel_hi, wdog_period_sel_lo};

	always_comb begin
		next_state       = state;
		next_cnt         = cnt + swr_pkg::CW'(1);
		next_reset_out_n = reset_out_n;
		case (state)
			swr_pkg::SWR_POR: begin
				next_reset_out_n = 1'b0;
				if (cnt >= swr_pkg::CW'(PWRUP_RST_CYC - 1)) begin
					next_state       = swr_pkg::SWR_RUN;
					next_cnt         = '0;
					next_reset_out_n = 1'b1;
				end
			end
			swr_pkg::SWR_RUN: begin
				next_reset_out_n = 1'b1;
				if (sel == swr_pkg::SEL_OFF || access_done)
					next_cnt = '0;
				else if (cnt >= wdog_limit(sel) - swr_pkg::CW'(1)) begin
					next_state       = swr_pkg::SWR_WRST;
					next_cnt         = '0;
					next_reset_out_n = 1'b0;
				end
			end
			swr_pkg::SWR_WRST: begin
				next_reset_out_n = 1'b0;
				if (cnt >= swr_pkg::CW'(WDOG_RST_CYC - 1)) begin
					next_state       = swr_pkg::SWR_RUN;
					next_cnt         = '0;
					next_reset_out_n = 1'b1;
				end
			end
			default: begin
				next_state = swr_pkg::SWR_POR;
				next_cnt   = '0;
			end
		endcase
		if (supply_low) begin
			next_state       = swr_pkg::SWR_POR;
			next_cnt         = '0;
			next_reset_out_n = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= swr_pkg::SWR_POR;
			cnt         <= '0;
			reset_out_n <= 1'b0;
		end else begin
			state       <= next_state;
			cnt         <= next_cnt;
			reset_out_n <= next_reset_out_n;
		end
	end

	// Open drain: driven low whenever reset is asserted
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			reset_oe <= 1'b1;
		else
			reset_oe <= ~next_reset_out_n;
	end

	//--------------------------------------------------------------------------
	// Access readiness and nonvolatile write timer
	//--------------------------------------------------------------------------
	logic [swr_pkg::CW-1:0] up_cnt;
	logic [swr_pkg::CW-1:0] next_up_cnt;
	logic [swr_pkg::CW-1:0] wc_cnt;
	logic [swr_pkg::CW-1:0] next_wc_cnt;
	swr_pkg::swr_ready_s    next_ready;
	logic                   next_addr_nack;

	always_comb begin
		next_up_cnt = up_cnt;
		if (supply_low)
			next_up_cnt = '0;
		else if (up_cnt < swr_pkg::CW'(WRITE_WAIT_CYC))
			next_up_cnt = up_cnt + swr_pkg::CW'(1);
		next_wc_cnt = wc_cnt;
		if (nv_write_stop)
			next_wc_cnt = swr_pkg::CW'(WRITE_CYC_CYC);
		else if (wc_cnt != '0)
			next_wc_cnt = wc_cnt - swr_pkg::CW'(1);
		next_ready.rd_ok   = next_up_cnt >= swr_pkg::CW'(READ_WAIT_CYC);
		next_ready.wr_ok   = next_up_cnt >= swr_pkg::CW'(WRITE_WAIT_CYC);
		next_ready.nv_busy = next_wc_cnt != '0;
		next_addr_nack     = next_wc_cnt != '0;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			up_cnt    <= '0;
			wc_cnt    <= '0;
			ready     <= '0;
			addr_nack <= 1'b0;
		end else begin
			up_cnt    <= next_up_cnt;
			wc_cnt    <= next_wc_cnt;
			ready     <= next_ready;
			addr_nack <= next_addr_nack;
		end
	end

	//--------------------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------------------
	// Length of the running write cycle, read by the checks only
	logic [swr_pkg::CW-1:0] nack_len;
	logic [swr_pkg::CW-1:0] next_nack_len;

	always_comb begin
		next_nack_len = nack_len;
		if (nv_write_stop)
			next_nack_len = '0;
		else if (addr_nack)
			next_nack_len = nack_len + swr_pkg::CW'(1);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			nack_len <= '0;
		else
			nack_len <= next_nack_len;
	end

	a_supply_drop_low: assert property (@(posedge mclk) disable iff (!rst_n)
		supply_low |=> !reset_out_n && reset_oe)
		else $error("reset not low after supply drop");
	a_reset_od_pair: assert property (@(posedge mclk) disable iff (!rst_n)
		reset_oe == !reset_out_n)
		else $error("open drain enable mismatch");
	a_nv_busy_nack: assert property (@(posedge mclk) disable iff (!rst_n)
		nv_write_stop |=> addr_nack ##1 addr_nack)
		else $error("address acked during write cycle");
	a_nv_cycle_ends: assert property (@(posedge mclk) disable iff (!rst_n)
		$fell(addr_nack) |-> nack_len == swr_pkg::CW'(WRITE_CYC_CYC))
		else $error("write cycle length wrong");
	a_wdog_off_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		state == swr_pkg::SWR_RUN && sel == swr_pkg::SEL_OFF && !supply_low
		|=> reset_out_n)
		else $error("disabled watchdog asserted reset");
	a_wdog_expire: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(state == swr_pkg::SWR_WRST) |-> !reset_out_n)
		else $error("watchdog expiry without reset");
	a_wdog_period: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(state == swr_pkg::SWR_WRST)
		|-> $past(cnt) == wdog_limit($past(sel)) - swr_pkg::CW'(1))
		else $error("watchdog period wrong");
	a_wrst_release: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(state) == swr_pkg::SWR_WRST && state == swr_pkg::SWR_RUN
		|-> $past(cnt) == swr_pkg::CW'(WDOG_RST_CYC - 1))
		else $error("watchdog reset length wrong");
	a_por_release: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(state) == swr_pkg::SWR_POR && state == swr_pkg::SWR_RUN
		|-> $past(cnt) == swr_pkg::CW'(PWRUP_RST_CYC - 1))
		else $error("power-up reset length wrong");
	a_glitch_drop: assert property (@(posedge mclk) disable iff (!rst_n)
		$changed(bus_clean) |-> $past(bus_raw, 2) == bus_clean)
		else $error("short pulse passed filter");

endmodule : swr_supervisor

// File: tb/swr_host.sv
`timescale 1ns/1ps
// -----------------------------------------------------------
// Host processor seen from the supervisor
// -----------------------------------------------------------
module swr_host (
	input  wire logic                mclk,
	input  wire swr_pkg::swr_ready_s ready,
	input  wire logic                addr_nack,
	output swr_pkg::swr_bus_s        bus,
	output logic                     acc,
	output logic                     nv_stop
);
	bit stalled = 1'b0;

	initial begin
		bus = 2'h3;
		acc = 1'b0;
		nv_stop = 1'b0;
	end

	// Waits for readiness and for the write cycle before a transfer
	task automatic access(input logic wr);
		int n;
		n = 0;
		// Let an edge pass so a busy flag launched just now is seen
		@(posedge mclk);
		while (((wr ? ready.wr_ok : ready.rd_ok) !== 1'b1
			|| addr_nack !== 1'b0) && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 5000) stalled = 1'b1;
		@(posedge mclk);
		acc <= 1'b1;
		nv_stop <= wr;
		@(posedge mclk);
		acc <= 1'b0;
		nv_stop <= 1'b0;
	endtask : access

	// Pulls the clock line low for n cycles from the current edge
	task automatic scl_low(input int n);
		bus.scl <= 1'b0;
		repeat (n) @(posedge mclk);
		bus.scl <= 1'b1;
	endtask : scl_low

	// Pulls the data line low for n cycles from the current edge
	task automatic sda_low(input int n);
		bus.sda <= 1'b0;
		repeat (n) @(posedge mclk);
		bus.sda <= 1'b1;
	endtask : sda_low
endmodule : swr_host

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int PU = 50;
	localparam int WR = 30;
	localparam int WC = 20;
	localparam int TL = 3;
	localparam int RW = 10;
	localparam int WW = 25;
	typedef struct {int sig; logic val; int at;} swr_note_s;
	logic               mclk = 1'b0;
	logic               rst_n = 1'b0;
	logic               supply_low = 1'b0;
	logic               wdog_period_sel_hi = 1'b1;
	logic               wdog_period_sel_lo = 1'b1;
	logic               access_done;
	logic               nv_write_stop;
	logic               reset_out_n;
	logic               reset_oe;
	logic               addr_nack;
	logic [6:0]         prev;
	logic [6:0]         cur;
	swr_pkg::swr_bus_s  bus_raw;
	swr_pkg::swr_bus_s  bus_clean;
	swr_pkg::swr_ready_s ready;
	swr_note_s          q[$];
	swr_note_s          nt;
	int                 lim[3] = '{120, 80, 40};
	int                 cyc = 0;
	int                 c;
	int                 r;
	int                 fails = 0;
	int                 total_checks = 0;
	bit                 armed = 0;

	swr_supervisor #(.WDOG_LONG_CYC(120), .WDOG_MID_CYC(80),
		.WDOG_SHORT_CYC(40), .WDOG_RST_CYC(WR), .PWRUP_RST_CYC(PU),
		.WRITE_CYC_CYC(WC), .READ_WAIT_CYC(RW), .WRITE_WAIT_CYC(WW)
	) i_dut (
		.mclk              (mclk),
		.rst_n             (rst_n),
		.bus_raw           (bus_raw),
		.supply_low        (supply_low),
		.wdog_period_sel_hi(wdog_period_sel_hi),
		.wdog_period_sel_lo(wdog_period_sel_lo),
		.access_done       (access_done),
		.nv_write_stop     (nv_write_stop),
		.reset_out_n       (reset_out_n),
		.reset_oe          (reset_oe),
		.bus_clean         (bus_clean),
		.ready             (ready),
		.addr_nack         (addr_nack)
	);

	swr_host i_host (
		.mclk     (mclk),
		.ready    (ready),
		.addr_nack(addr_nack),
		.bus      (bus_raw),
		.acc      (access_done),
		.nv_stop  (nv_write_stop)
	);

	always #50 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	task automatic mismatch(input string m);
		fails++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : mismatch

	task automatic expect_at(input int s, input logic v, input int at);
		q.push_back('{s, v, at});
	endtask : expect_at

	task automatic wait_to(input int t);
		while (cyc < t) @(posedge mclk);
	endtask : wait_to

	task automatic conclude();
		if (q.size() != 0) mismatch("edge missing");
		if (i_host.stalled) mismatch("host wait ran out");
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	// -----------------------------------------------------------
	// Output watcher: each edge must match the oldest note
	// -----------------------------------------------------------
	always @(negedge mclk) if (armed) begin
		cur = {ready, bus_clean.sda, reset_out_n, addr_nack, bus_clean.scl};
		total_checks++;
		if (reset_oe !== ~reset_out_n) mismatch("drive enable");
		for (int i = 6; i >= 0; i--) if (cur[i] !== prev[i]) begin
			total_checks++;
			if (q.size() == 0) mismatch($sformatf("edge on %0d", i));
			else begin
				nt = q.pop_front();
				if (nt.sig != i || nt.val !== cur[i] || cyc < nt.at - TL
					|| cyc > nt.at + TL)
					mismatch($sformatf("sig %0d cyc %0d", i, cyc));
			end
		end
		prev = cur;
	end

	initial begin
		#2000000;
		mismatch("timeout");
		conclude();
	end

	initial begin
		void'($urandom(40886));
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		prev = 7'h09;
		armed = 1;
		expect_at(6, 1'b1, cyc + RW + 1);
		expect_at(5, 1'b1, cyc + WW + 1);
		expect_at(2, 1'b1, cyc + PU + 2);
		wait_to(cyc + PU + 8);
		@(posedge mclk);
		supply_low <= 1'b1;
		expect_at(6, 1'b0, cyc + 2);
		expect_at(5, 1'b0, cyc + 2);
		expect_at(2, 1'b0, cyc + 2);
		repeat (3) @(posedge mclk);
		supply_low <= 1'b0;
		expect_at(6, 1'b1, cyc + RW + 1);
		expect_at(5, 1'b1, cyc + WW + 1);
		expect_at(2, 1'b1, cyc + PU + 2);
		wait_to(cyc + PU + 8);
		for (int s = 0; s < 3; s++) begin
			@(posedge mclk);
			{wdog_period_sel_hi, wdog_period_sel_lo} <= 2'(s);
			i_host.access(1'b0);
			c = cyc;
			expect_at(2, 1'b0, c + 1 + lim[s]);
			expect_at(2, 1'b1, c + 1 + lim[s] + WR);
			wait_to(c + lim[s] + WR + 4);
		end
		@(posedge mclk);
		{wdog_period_sel_hi, wdog_period_sel_lo} <= 2'h3;
		wait_to(cyc + 200);
		{wdog_period_sel_hi, wdog_period_sel_lo} <= 2'h2;
		repeat (6) begin
			repeat (5 + $urandom % 25) @(posedge mclk);
			i_host.access(1'b0);
		end
		{wdog_period_sel_hi, wdog_period_sel_lo} <= 2'h3;
		i_host.access(1'b1);
		c = cyc;
		expect_at(4, 1'b1, c + 1);
		expect_at(1, 1'b1, c + 1);
		expect_at(4, 1'b0, c + 1 + WC);
		expect_at(1, 1'b0, c + 1 + WC);
		i_host.access(1'b0);
		@(posedge mclk);
		i_host.scl_low(1);
		wait_to(cyc + 10);
		@(posedge mclk);
		c = cyc;
		expect_at(0, 1'b0, c + 4);
		expect_at(0, 1'b1, c + 9);
		i_host.scl_low(5);
		wait_to(c + 20);
		@(posedge mclk);
		i_host.sda_low(1);
		wait_to(cyc + 10);
		@(posedge mclk);
		c = cyc;
		r = 3 + $urandom % 6;
		expect_at(3, 1'b0, c + 4);
		expect_at(3, 1'b1, c + 4 + r);
		i_host.sda_low(r);
		wait_to(c + r + 15);
		conclude();
	end
endmodule : tb_top
